/* File: sfs_cfg.svh */
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

// register byte offsets, step data window as upper address nibble
`define SFS_ADR_CTRL       8'h00
`define SFS_ADR_STATUS     8'h04
`define SFS_ADR_IRQ_STAT   8'h08
`define SFS_ADR_IRQ_MASK   8'h0C
`define SFS_ADR_SCK_DIV    8'h10
`define SFS_ADR_ERASE_CFG  8'h14
`define SFS_ADR_ERASE_MAP  8'h18
`define SFS_ADR_ID_EXPECT  8'h1C
`define SFS_ADR_ID_READ    8'h20
`define SFS_ADR_STEP_COUNT 8'h24
`define SFS_ADR_STEP_ADDR  8'h28
`define SFS_ADR_STEP_CTRL  8'h2C
`define SFS_ADR_STEP_DATA  4'h3

// control bits
`define SFS_CTRL_INIT      0
`define SFS_CTRL_EXIT      1
`define SFS_CTRL_ERASE     2
`define SFS_CTRL_HOLD      3
`define SFS_CTRL_IDCHK     4
`define SFS_CTRL_PROGDONE  5

// interrupt status bits
`define SFS_IRQ_DONE       0
`define SFS_IRQ_IDFAIL     1
`define SFS_IRQ_CFGERR     2

// erase configuration fields
`define SFS_ECFG_OP_LSB    0
`define SFS_ECFG_UNIT_LSB  8
`define SFS_ECFG_WAIT_LSB  16

// reset values
`define SFS_SCKDIV_RST     16'h0003
`define SFS_ECFG_RST       32'h00C8_02D8
`define SFS_EMAP_RST       24'hD8_00_00
`define SFS_IDEXP_RST      24'h00_00_00

// fixed command bytes and step counts
`define SFS_OP_WREN        8'h06
`define SFS_OP_ID          8'h9F
`define SFS_DUMMY          8'hFF
`define SFS_ID_STEPS       5'h03
`define SFS_ERASE_STEPS    5'h07
`define SFS_MAX_BYTES      5'h10

// timing
`define SFS_CLK_PERIOD_NS  8
`define SFS_MS_NS          1000000

`endif

/* File: sfs_pkg.sv */
package sfs_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_DELAY = 4'b1000
  } sfs_fsm_t;

  typedef enum logic [1:0] {
    MODE_INIT  = 2'h0,
    MODE_EXIT  = 2'h1,
    MODE_ERASE = 2'h2,
    MODE_ID    = 2'h3
  } sfs_mode_t;

  typedef enum logic [1:0] {
    ACT_CS_LO = 2'h0,
    ACT_CS_HI = 2'h1,
    ACT_SEND  = 2'h2,
    ACT_DELAY = 2'h3
  } sfs_act_t;

  typedef struct packed {
    sfs_act_t          act;
    logic [15:0]       p1;
    logic [15:0][7:0]  bytes;
  } sfs_step_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sfs_wb_req_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } sfs_spi_t;

  typedef struct packed {
    sfs_fsm_t    fsm;
    sfs_mode_t   mode;
    logic [4:0]  idx;
    logic [4:0]  bidx;
    logic [2:0]  bitc;
    logic [15:0] div;
    logic [16:0] tick;
    logic [15:0] ms;
    logic [7:0]  sh;
    logic [7:0]  rx;
    logic [23:0] id;
    sfs_spi_t    spi;
    logic        hold_n;
    logic        irq;
    logic        ack;
    logic [31:0] rdat;
    logic        hold_en;
    logic        id_chk;
    logic        prog_done;
    logic [2:0]  istat;
    logic [2:0]  imask;
    logic [15:0] sck_div;
    logic [31:0] ecfg;
    logic [23:0] emap;
    logic [23:0] id_exp;
    logic [4:0]  cnt_init;
    logic [4:0]  cnt_exit;
    logic [4:0]  saddr;
  } sfs_state_t;

endpackage

/* File: sfs_seq.sv */
`timescale 1ns/1ps
`include "sfs_cfg.svh"
// Notes on behaviour
// R01: step-count steps, at most sixteen, ascending index order
// R02: select steps drive chip select low/high
// R03: send step shifts up to sixteen bytes
// R04: delay step waits milliseconds, select unchanged
// R05: erase: write-enable frame, opcode frame, wait
// R06: erase opcode is configurable
// R07: unit size must match opcode, else error
// R08: hold target in reset while a sequence runs
// R09: read flash id, flag mismatch
// R10: serial clock rate is configurable
// R11: init on connect, exit after programming
module sfs_seq
  import sfs_pkg::*;
#(
  parameter int MS_CYCLES = `SFS_MS_NS / `SFS_CLK_PERIOD_NS
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire sfs_wb_req_t wb_req,
  output logic             wb_ack,
  output logic [31:0]      wb_dat_o,
  output sfs_spi_t         spi,
  input  wire logic        spi_miso,
  output logic             target_hold_low,
  output logic             irq
);

  sfs_state_t  s_q;
  sfs_state_t  s_d;
  sfs_step_t   cur;
  logic [1:0]  m_act [32];
  logic [15:0] m_p1  [32];
  logic [127:0] m_dat [32];
  logic        req;
  logic        commit;
  logic        cfg_err;
  logic [7:0]  map_op;
  logic [4:0]  nsteps;
  logic [4:0]  nbytes;

  function automatic logic [4:0] clamp16(input logic [15:0] v);
    return (v > 16'(`SFS_MAX_BYTES)) ? `SFS_MAX_BYTES : v[4:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // R05: built-in erase sequence
  function automatic sfs_step_t builtin(input sfs_mode_t m, input logic [4:0] i,
                                        input logic [7:0] op, input logic [15:0] wt);
    sfs_step_t st;
    st = '0;
    if (m == MODE_ID)
    begin
      st.act = (i == 5'h00) ? ACT_CS_LO : (i == 5'h01) ? ACT_SEND : ACT_CS_HI;
      st.p1 = 16'h0004;
      st.bytes[0] = `SFS_OP_ID;
      st.bytes[1] = `SFS_DUMMY;
      st.bytes[2] = `SFS_DUMMY;
      st.bytes[3] = `SFS_DUMMY;
    end
    else
    begin
      case (i)
        5'h00, 5'h03: st.act = ACT_CS_LO;
        5'h01:
        begin
          st.act = ACT_SEND;
          st.p1 = 16'h0001;
          st.bytes[0] = `SFS_OP_WREN;
        end
        5'h02, 5'h05: st.act = ACT_CS_HI;
        5'h04:
        begin
          st.act = ACT_SEND;
          st.p1 = 16'h0004;
          st.bytes[0] = op;
        end
        default:
        begin
          st.act = ACT_DELAY;
          st.p1 = wt;
        end
      endcase
    end
    return st;
  endfunction

  assign req    = wb_req.cyc && wb_req.stb;
  assign commit = req && wb_req.we && s_q.ack;

  // erase unit check
  always_comb
  begin
    case (s_q.ecfg[`SFS_ECFG_UNIT_LSB +: 2])
      2'h0:    map_op = s_q.emap[7:0];
      2'h1:    map_op = s_q.emap[15:8];
      default: map_op = s_q.emap[23:16];
    endcase
  end
  // R07: mismatch check
  assign cfg_err = (s_q.ecfg[`SFS_ECFG_UNIT_LSB +: 2] == 2'h3) ||
                   (map_op != s_q.ecfg[`SFS_ECFG_OP_LSB +: 8]);

  always_comb
  begin
    cur = '0;
    case (s_q.mode)
      MODE_INIT, MODE_EXIT:
      begin
        cur.act   = sfs_act_t'(m_act[{s_q.mode == MODE_EXIT, s_q.idx[3:0]}]);
        cur.p1    = m_p1[{s_q.mode == MODE_EXIT, s_q.idx[3:0]}];
        cur.bytes = m_dat[{s_q.mode == MODE_EXIT, s_q.idx[3:0]}];
      end
      // R06: configured opcode
      default: cur = builtin(s_q.mode, s_q.idx, s_q.ecfg[`SFS_ECFG_OP_LSB +: 8],
                             s_q.ecfg[`SFS_ECFG_WAIT_LSB +: 16]);
    endcase
    case (s_q.mode)
      MODE_INIT:  nsteps = clamp16({11'h000, s_q.cnt_init});
      MODE_EXIT:  nsteps = clamp16({11'h000, s_q.cnt_exit});
      MODE_ERASE: nsteps = `SFS_ERASE_STEPS;
      default:    nsteps = `SFS_ID_STEPS;
    endcase
    // R03: at most sixteen bytes
    nbytes = clamp16(cur.p1);
  end

  always_comb
  begin
    s_d = s_q;
    s_d.ack = req && !s_q.ack;
    if (req && !s_q.ack)
    begin
      case ({wb_req.adr[7:2], 2'b00})
        `SFS_ADR_CTRL:
          s_d.rdat = {26'h0, s_q.prog_done, s_q.id_chk, s_q.hold_en, 3'h0};
        `SFS_ADR_STATUS:
          s_d.rdat = {11'h0, s_q.idx, 6'h0, s_q.mode, 6'h0, cfg_err, s_q.fsm != ST_IDLE};
        `SFS_ADR_IRQ_STAT:   s_d.rdat = {29'h0, s_q.istat};
        `SFS_ADR_IRQ_MASK:   s_d.rdat = {29'h0, s_q.imask};
        `SFS_ADR_SCK_DIV:    s_d.rdat = {16'h0, s_q.sck_div};
        `SFS_ADR_ERASE_CFG:  s_d.rdat = s_q.ecfg;
        `SFS_ADR_ERASE_MAP:  s_d.rdat = {8'h0, s_q.emap};
        `SFS_ADR_ID_EXPECT:  s_d.rdat = {8'h0, s_q.id_exp};
        `SFS_ADR_ID_READ:    s_d.rdat = {8'h0, s_q.id};
        `SFS_ADR_STEP_COUNT: s_d.rdat = {19'h0, s_q.cnt_exit, 3'h0, s_q.cnt_init};
        `SFS_ADR_STEP_ADDR:  s_d.rdat = {27'h0, s_q.saddr};
        `SFS_ADR_STEP_CTRL:  s_d.rdat = {8'h0, m_p1[s_q.saddr], 6'h0, m_act[s_q.saddr]};
        default:
          s_d.rdat = (wb_req.adr[7:4] == `SFS_ADR_STEP_DATA) ?
                     m_dat[s_q.saddr][32*wb_req.adr[3:2] +: 32] : 32'h0;
      endcase
    end
    if (commit)
    begin
      case ({wb_req.adr[7:2], 2'b00})
        `SFS_ADR_CTRL:
          if (wb_req.sel[0])
          begin
            s_d.hold_en   = wb_req.dat[`SFS_CTRL_HOLD];
            s_d.id_chk    = wb_req.dat[`SFS_CTRL_IDCHK];
            s_d.prog_done = wb_req.dat[`SFS_CTRL_PROGDONE];
            if (s_q.fsm == ST_IDLE)
            begin
              s_d.idx = 5'h00;
              s_d.id  = 24'h0;
              // R11: init runs on connect, optionally after id read
              if (wb_req.dat[`SFS_CTRL_INIT])
              begin
                s_d.fsm  = ST_FETCH;
                s_d.mode = s_q.id_chk ? MODE_ID : MODE_INIT;
              end
              // R11: exit only once programming is done
              else if (wb_req.dat[`SFS_CTRL_EXIT] && s_q.prog_done)
              begin
                s_d.fsm  = ST_FETCH;
                s_d.mode = MODE_EXIT;
              end
              // R07: erase refused on bad unit setting
              else if (wb_req.dat[`SFS_CTRL_ERASE] && !cfg_err)
              begin
                s_d.fsm  = ST_FETCH;
                s_d.mode = MODE_ERASE;
              end
            end
          end
        `SFS_ADR_IRQ_STAT:   s_d.istat = s_q.istat & ~(wb_req.sel[0] ? wb_req.dat[2:0] : 3'h0);
        `SFS_ADR_IRQ_MASK:   s_d.imask = 3'(merge({29'h0, s_q.imask}, wb_req.dat, wb_req.sel));
        // R10: serial clock rate
        `SFS_ADR_SCK_DIV:    s_d.sck_div = 16'(merge({16'h0, s_q.sck_div}, wb_req.dat,
                                                     wb_req.sel));
        `SFS_ADR_ERASE_CFG:  s_d.ecfg = merge(s_q.ecfg, wb_req.dat, wb_req.sel);
        `SFS_ADR_ERASE_MAP:  s_d.emap = 24'(merge({8'h0, s_q.emap}, wb_req.dat, wb_req.sel));
        `SFS_ADR_ID_EXPECT:  s_d.id_exp = 24'(merge({8'h0, s_q.id_exp}, wb_req.dat,
                                                    wb_req.sel));
        `SFS_ADR_STEP_COUNT:
        begin
          if (wb_req.sel[0])
            s_d.cnt_init = wb_req.dat[4:0];
          if (wb_req.sel[1])
            s_d.cnt_exit = wb_req.dat[12:8];
        end
        `SFS_ADR_STEP_ADDR:  if (wb_req.sel[0]) s_d.saddr = wb_req.dat[4:0];
        default: ;
      endcase
      if (wb_req.dat[`SFS_CTRL_ERASE] && wb_req.sel[0] && cfg_err &&
          {wb_req.adr[7:2], 2'b00} == `SFS_ADR_CTRL && s_q.fsm == ST_IDLE &&
          !wb_req.dat[`SFS_CTRL_INIT] && !wb_req.dat[`SFS_CTRL_EXIT])
        s_d.istat[`SFS_IRQ_CFGERR] = 1'b1;
    end
    case (s_q.fsm)
      ST_FETCH:
        // R01: stop after the configured count
        if (s_q.idx >= nsteps)
        begin
          // R09: compare identity
          if (s_q.mode == MODE_ID && s_q.id != s_q.id_exp)
          begin
            s_d.istat[`SFS_IRQ_IDFAIL] = 1'b1;
            s_d.fsm = ST_IDLE;
          end
          else if (s_q.mode == MODE_ID)
          begin
            s_d.mode = MODE_INIT;
            s_d.idx  = 5'h00;
          end
          else
          begin
            s_d.istat[`SFS_IRQ_DONE] = 1'b1;
            s_d.fsm = ST_IDLE;
          end
        end
        else
        begin
          s_d.idx = s_q.idx + 5'h01;
          case (cur.act)
            // R02: select low and high
            ACT_CS_LO: s_d.spi.cs_n = 1'b0;
            ACT_CS_HI: s_d.spi.cs_n = 1'b1;
            // R05: frames go out byte by byte
            ACT_SEND:
              if (nbytes != 5'h00)
              begin
                s_d.idx      = s_q.idx;
                s_d.fsm      = ST_SHIFT;
                s_d.bidx     = 5'h00;
                s_d.bitc     = 3'h0;
                s_d.div      = 16'h0;
                s_d.sh       = cur.bytes[0];
                s_d.spi.mosi = cur.bytes[0][7];
              end
            default:
            begin
              s_d.idx  = s_q.idx;
              s_d.fsm  = ST_DELAY;
              s_d.ms   = cur.p1;
              s_d.tick = 17'h0;
            end
          endcase
        end
      ST_SHIFT:
        // R10: half period is sck_div+1 cycles
        if (s_q.div != s_q.sck_div)
          s_d.div = s_q.div + 16'h1;
        else
        begin
          s_d.div = 16'h0;
          s_d.spi.sck = !s_q.spi.sck;
          if (!s_q.spi.sck)
            s_d.rx = {s_q.rx[6:0], spi_miso};
          else if (s_q.bitc != 3'h7)
          begin
            s_d.bitc     = s_q.bitc + 3'h1;
            s_d.sh       = {s_q.sh[6:0], 1'b0};
            s_d.spi.mosi = s_q.sh[6];
          end
          else
          begin
            // R03: next byte of the list, in order
            s_d.bitc = 3'h0;
            s_d.bidx = s_q.bidx + 5'h01;
            if (s_q.mode == MODE_ID)
              s_d.id = {s_q.id[15:0], s_q.rx};
            if (s_q.bidx + 5'h01 >= nbytes)
            begin
              s_d.fsm = ST_FETCH;
              s_d.idx = s_q.idx + 5'h01;
            end
            else
            begin
              s_d.sh       = cur.bytes[s_q.bidx[3:0] + 4'h1];
              s_d.spi.mosi = cur.bytes[s_q.bidx[3:0] + 4'h1][7];
            end
          end
        end
      ST_DELAY:
        // R04: millisecond wait, select untouched
        if (s_q.ms == 16'h0)
        begin
          s_d.fsm = ST_FETCH;
          s_d.idx = s_q.idx + 5'h01;
        end
        else if (s_q.tick == 17'(MS_CYCLES - 1))
        begin
          s_d.tick = 17'h0;
          s_d.ms   = s_q.ms - 16'h1;
        end
        else
          s_d.tick = s_q.tick + 17'h1;
      default: s_d.spi.sck = 1'b0;
    endcase
    // R08: hold target while sequencing
    s_d.hold_n = !(s_d.hold_en && s_d.fsm != ST_IDLE);
    s_d.irq    = |(s_d.istat & s_d.imask);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.fsm      <= ST_IDLE;
      s_q.spi.cs_n <= 1'b1;
      s_q.hold_n   <= 1'b1;
      s_q.sck_div  <= `SFS_SCKDIV_RST;
      s_q.ecfg     <= `SFS_ECFG_RST;
      s_q.emap     <= `SFS_EMAP_RST;
      s_q.id_exp   <= `SFS_IDEXP_RST;
    end
    else if (ce)
      s_q <= s_d;
  end

  // step list storage, written through the step window
  always_ff @(posedge clk)
  begin
    if (ce && commit && {wb_req.adr[7:2], 2'b00} == `SFS_ADR_STEP_CTRL)
    begin
      if (wb_req.sel[0])
        m_act[s_q.saddr] <= wb_req.dat[1:0];
      m_p1[s_q.saddr] <= 16'(merge({16'h0, m_p1[s_q.saddr]}, wb_req.dat >> 8,
                                   {1'b0, wb_req.sel[3:1]}));
    end
    if (ce && commit && wb_req.adr[7:4] == `SFS_ADR_STEP_DATA)
      m_dat[s_q.saddr][32*wb_req.adr[3:2] +: 32] <=
        merge(m_dat[s_q.saddr][32*wb_req.adr[3:2] +: 32], wb_req.dat, wb_req.sel);
  end

  assign wb_ack          = s_q.ack;
  assign wb_dat_o        = s_q.rdat;
  assign spi             = s_q.spi;
  assign target_hold_low = s_q.hold_n;
  assign irq             = s_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_step_advance: assert property (ce && s_q.fsm == ST_FETCH && s_q.idx < nsteps &&  // R01
    (cur.act == ACT_CS_LO || cur.act == ACT_CS_HI) |=> s_q.idx == $past(s_q.idx) + 5'h01)
    else $error("step index did not advance by one");
  a_select_low: assert property (ce && s_q.fsm == ST_FETCH && s_q.idx < nsteps &&  // R02
    cur.act == ACT_CS_LO |=> !spi.cs_n)
    else $error("select not driven low");
  a_byte_limit: assert property (s_q.fsm == ST_SHIFT |-> s_q.bidx < `SFS_MAX_BYTES)  // R03
    else $error("more than sixteen bytes sent");
  a_delay_select: assert property (s_q.fsm == ST_DELAY |=> $stable(spi.cs_n))  // R04
    else $error("select moved during delay");
  a_erase_wren: assert property (ce && s_q.fsm == ST_FETCH && s_q.mode == MODE_ERASE &&  // R05
    s_q.idx == 5'h01 |=> s_q.fsm == ST_SHIFT && s_q.sh == `SFS_OP_WREN)
    else $error("erase did not open with write enable");
  a_erase_opcode: assert property (ce && s_q.fsm == ST_FETCH && s_q.mode == MODE_ERASE &&  // R06
    s_q.idx == 5'h04 |=> s_q.sh == $past(s_q.ecfg[7:0]))
    else $error("erase opcode not the configured one");
  a_cfg_refuse: assert property (ce && commit && s_q.fsm == ST_IDLE && cfg_err &&  // R07
    {wb_req.adr[7:2], 2'b00} == `SFS_ADR_CTRL && wb_req.sel[0] && wb_req.dat[2:0] == 3'h4
    |=> s_q.fsm == ST_IDLE && s_q.istat[`SFS_IRQ_CFGERR])
    else $error("erase started with bad unit setting");
  a_hold_reset: assert property (s_q.fsm != ST_IDLE && s_q.hold_en |-> !target_hold_low)  // R08
    else $error("target not held in reset");
  a_id_fail: assert property (ce && s_q.fsm == ST_FETCH && s_q.mode == MODE_ID &&  // R09
    s_q.idx >= nsteps && s_q.id != s_q.id_exp |=> s_q.fsm == ST_IDLE && s_q.istat[1])
    else $error("identity mismatch not reported");
  a_sck_rate: assert property (ce && s_q.fsm == ST_SHIFT && s_q.div != s_q.sck_div  // R10
    |=> $stable(spi.sck))
    else $error("serial clock toggled early");
  a_exit_gate: assert property (ce && commit && s_q.fsm == ST_IDLE && !s_q.prog_done &&  // R11
    {wb_req.adr[7:2], 2'b00} == `SFS_ADR_CTRL && wb_req.sel[0] && wb_req.dat[2:0] == 3'h2
    |=> s_q.fsm == ST_IDLE)
    else $error("exit list ran before programming done");

  c_init_done: cover property (s_q.mode == MODE_INIT && s_q.istat[`SFS_IRQ_DONE]);
  c_id_fail: cover property (s_q.istat[`SFS_IRQ_IDFAIL]);
  c_erase_wait: cover property (s_q.mode == MODE_ERASE && s_q.fsm == ST_DELAY);
  c_irq_out: cover property ($rose(irq));

endmodule // sfs_seq

/* File: sfs_flash_model.sv */
`timescale 1ns/1ps
module sfs_flash_model
  import sfs_pkg::*;
#(
  // identity value is arbitrary
  parameter logic [23:0] ID = 24'h5A_C3_17
)(
  input  wire sfs_spi_t spi,
  output logic          miso
);
  logic [7:0]  sh;
  logic [2:0]  nb;
  int          fb;
  logic [23:0] out;
  logic [7:0]  byte_q[$];
  int          frames;
  int          cut;

  initial
  begin
    miso = 1'b0;
    nb = 3'h0;
    fb = 0;
    out = 24'hA5_96_3C;
    frames = 0;
    cut = 0;
  end

  // whole bytes logged in frame order
  always @(posedge spi.sck)
    if (!spi.cs_n)
    begin
      sh = {sh[6:0], spi.mosi};
      nb = nb + 3'h1;
      if (nb == 3'h0)
      begin
        byte_q.push_back(sh);
        if (fb == 0 && sh == `SFS_OP_ID)
          out = ID;
        fb++;
      end
    end

  // answer moves on the falling edge, mode 0
  always @(negedge spi.sck)
    if (!spi.cs_n)
    begin
      miso <= out[23];
      out <= {out[22:0], ~out[0]};
    end

  always @(negedge spi.cs_n)
  begin
    nb = 3'h0;
    fb = 0;
  end

  // released line shows no stale level
  always @(posedge spi.cs_n)
  begin
    frames++;
    if (nb != 3'h0)
      cut++;
    miso <= ~miso;
  end
endmodule // sfs_flash_model

/* File: spi_flash_cmd_sequencer_tb.sv */
`timescale 1ns/1ps
`include "sfs_cfg.svh"
module spi_flash_cmd_sequencer_tb;
  import sfs_pkg::*;
  localparam logic [23:0] FID = 24'h5A_C3_17;
  logic        clk;
  logic        rst;
  logic        ce;
  sfs_wb_req_t req;
  logic        ack;
  logic [31:0] rdat;
  sfs_spi_t    spi;
  logic        miso;
  logic        hold_n;
  logic        irq;
  logic [31:0] v;
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc_n = 0;

  sfs_seq #(.MS_CYCLES(10)) i_dut (.clk(clk), .rst(rst), .ce(ce), .wb_req(req), .wb_ack(ack),
    .wb_dat_o(rdat), .spi(spi), .spi_miso(miso), .target_hold_low(hold_n), .irq(irq));
  sfs_flash_model #(.ID(FID)) i_flash (.spi(spi), .miso(miso));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      bad_count++;
    v = rdat;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(v, e);
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    if (n >= 3000)
      bad_count++;
  endtask

  task automatic log_is(input int b0, input logic [7:0] e[$]);
    check(32'(i_flash.byte_q.size() - b0), 32'(e.size()));
    foreach (e[k])
      check({24'h0, i_flash.byte_q[b0 + k]}, {24'h0, e[k]});
  endtask

  task automatic put_step(input logic [4:0] ix, input sfs_act_t a, input logic [15:0] p,
                          input logic [127:0] b);
    wr(`SFS_ADR_STEP_ADDR, {27'h0, ix});
    for (int k = 0; k < 4; k++)
      wr({`SFS_ADR_STEP_DATA, k[1:0], 2'b00}, b[32*k +: 32]);
    wr(`SFS_ADR_STEP_CTRL, {8'h0, p, 6'h0, a});
  endtask

  task automatic t_reset();
    check({29'h0, spi}, 32'h4);
    check({31'h0, hold_n}, 32'h1);
    rd_chk(`SFS_ADR_SCK_DIV, 32'h3);
    rd_chk(`SFS_ADR_ERASE_CFG, `SFS_ECFG_RST);
    rd_chk(`SFS_ADR_ERASE_MAP, {8'h0, `SFS_EMAP_RST});
    rd_chk(8'h40, 32'h0);
    wr(`SFS_ADR_SCK_DIV, 32'h1);
    rd_chk(`SFS_ADR_SCK_DIV, 32'h1);
    wr(`SFS_ADR_IRQ_MASK, 32'h7);
  endtask

  task automatic t_erase(input logic [7:0] op, input logic [1:0] u, input logic [23:0] m);
    int n;
    int b0;
    int f0;
    b0 = i_flash.byte_q.size();
    f0 = i_flash.frames;
    wr(`SFS_ADR_ERASE_MAP, {8'h0, m});
    wr(`SFS_ADR_ERASE_CFG, {16'd3, 6'h0, u, op});
    wr(`SFS_ADR_CTRL, 32'h0C);
    @(posedge clk);
    check({31'h0, hold_n}, 32'h0);
    wait_irq(n);
    // five bytes at half period 2, then a 3 ms wait of 10 cycles each
    check({31'h0, n >= 188 && n <= 240}, 32'h1);
    log_is(b0, '{`SFS_OP_WREN, op, 8'h00, 8'h00, 8'h00});
    check(32'(i_flash.frames - f0), 32'd2);
    rd_chk(`SFS_ADR_IRQ_STAT, 32'h1);
    wr(`SFS_ADR_IRQ_STAT, 32'h1);
    check({31'h0, hold_n}, 32'h1);
    check({31'h0, irq}, 32'h0);
  endtask

  task automatic t_unit_mismatch();
    int b0;
    b0 = i_flash.byte_q.size();
    wr(`SFS_ADR_IRQ_MASK, 32'h3);
    wr(`SFS_ADR_ERASE_CFG, {16'd3, 6'h0, 2'h1, 8'hD8});
    // idle, mismatch flagged, last run was erase ending at index 7
    rd_chk(`SFS_ADR_STATUS, 32'h0007_0202);
    wr(`SFS_ADR_CTRL, 32'h04);
    repeat (20) @(posedge clk);
    rd_chk(`SFS_ADR_IRQ_STAT, 32'h4);
    check({31'h0, irq}, 32'h0);
    wr(`SFS_ADR_IRQ_MASK, 32'h7);
    @(posedge clk);
    check({31'h0, irq}, 32'h1);
    check(32'(i_flash.byte_q.size() - b0), 32'd0);
    wr(`SFS_ADR_IRQ_STAT, 32'h4);
  endtask

  task automatic t_id_and_lists();
    int n;
    int b0;
    int f0;
    b0 = i_flash.byte_q.size();
    wr(`SFS_ADR_ID_EXPECT, {8'h0, FID ^ 24'h1});
    // id check bit must already be stored when init starts
    wr(`SFS_ADR_CTRL, 32'h10);
    wr(`SFS_ADR_CTRL, 32'h11);
    wait_irq(n);
    rd_chk(`SFS_ADR_IRQ_STAT, 32'h2);
    rd_chk(`SFS_ADR_ID_READ, {8'h0, FID});
    log_is(b0, '{8'h9F, 8'hFF, 8'hFF, 8'hFF});
    wr(`SFS_ADR_IRQ_STAT, 32'h2);
    wr(`SFS_ADR_ID_EXPECT, {8'h0, FID});
    wr(`SFS_ADR_STEP_COUNT, 32'h0105);
    put_step(5'h00, ACT_CS_LO, 16'd0, 128'h0);
    put_step(5'h01, ACT_SEND, 16'd16, 128'h0F0E0D0C_0B0A0908_07060504_03020100);
    put_step(5'h02, ACT_DELAY, 16'd2, 128'h0);
    put_step(5'h03, ACT_SEND, 16'd1, 128'h5A);
    put_step(5'h04, ACT_SEND, 16'd0, 128'hC3);
    put_step(5'h05, ACT_CS_HI, 16'd0, 128'h0);
    put_step(5'h10, ACT_CS_HI, 16'd0, 128'h0);
    b0 = i_flash.byte_q.size();
    f0 = i_flash.frames;
    wr(`SFS_ADR_CTRL, 32'h11);
    wait_irq(n);
    // 21 bytes at 32 cycles plus a 2 ms wait of 10 cycles each
    check({31'h0, n >= 690 && n <= 760}, 32'h1);
    log_is(b0, '{8'h9F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h5A});
    check(32'(i_flash.frames - f0), 32'd1);
    check({31'h0, spi.cs_n}, 32'h0);
    rd_chk(`SFS_ADR_IRQ_STAT, 32'h1);
    wr(`SFS_ADR_IRQ_STAT, 32'h1);
    wr(`SFS_ADR_CTRL, 32'h02);
    repeat (20) @(posedge clk);
    check({31'h0, spi.cs_n}, 32'h0);
    // programming done must be stored before exit is started
    wr(`SFS_ADR_CTRL, 32'h20);
    wr(`SFS_ADR_CTRL, 32'h22);
    wait_irq(n);
    check({31'h0, spi.cs_n}, 32'h1);
    check(32'(i_flash.frames - f0), 32'd2);
    check(32'(i_flash.cut), 32'd0);
  endtask

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_erase(8'hD8, 2'h2, `SFS_EMAP_RST);
    t_erase(8'h20, 2'h0, 24'hD8_52_20);
    t_unit_mismatch();
    t_id_and_lists();
    summarize();
  end
endmodule // spi_flash_cmd_sequencer_tb
